// ==== verilog/mtp_pkg.sv ====
// shared constants for the six-output motor pwm timer
package mtp_pkg;
   // clock and switching rate
   localparam int          CLK_HZ      = 10_000_000;
   localparam int          PWM_HZ      = 16_000;
   // center-aligned period is two counter sweeps
   localparam logic [15:0] MOD_RST     = 16'(CLK_HZ / (2 * PWM_HZ));
   localparam logic [15:0] INIT_RST    = 16'h0000;
   localparam logic [15:0] DEAD_RST    = 16'h000a;
   localparam logic [15:0] CHV_RST     = 16'h0000;
   localparam logic [7:0]  POL_RST     = 8'h15;
   localparam logic [1:0]  DBG_RST     = 2'h0;
   localparam logic [1:0]  DBG_RUN     = 2'h3;
   // access port addresses
   localparam logic [3:0]  A_INIT      = 4'h8;
   localparam logic [3:0]  A_MOD       = 4'h9;
   localparam logic [3:0]  A_DEAD      = 4'ha;
   localparam logic [3:0]  A_POL       = 4'hb;
   localparam logic [3:0]  A_CONF      = 4'hc;
   localparam logic [3:0]  A_LOAD      = 4'hd;
   localparam logic [3:0]  A_CNT       = 4'he;
   localparam logic [3:0]  A_STAT      = 4'hf;
   // control word fields
   localparam int          B_SIGNED    = 0;
   localparam int          B_DBG_LO    = 1;
   localparam int          B_TRIG_EN   = 3;
   localparam int          B_LOAD      = 0;
   localparam int          NUM_PAIRS   = 3;
   localparam int          NUM_CH      = 8;
   typedef enum logic {
      DIR_UP   = 1'b0,
      DIR_DOWN = 1'b1
   } mtp_dir_t;
endpackage

// ==== verilog/mtp_dt_if.sv ====
// carrier between pwm core and dead-time unit
`timescale 1ns/100ps
interface mtp_dt_if #(parameter int NP = 3);
   logic [NP-1:0] raw;
   logic [15:0]   dead;
   logic [NP-1:0] top;
   logic [NP-1:0] bot;
   modport ctl (output raw, output dead, input top, input bot);
   modport dt  (input raw, input dead, output top, output bot);
endinterface

// ==== verilog/mtp_dead_time.sv ====
// dead-time insertion for complementary phase pairs
`timescale 1ns/100ps
module mtp_dead_time #(
   parameter int NP = 3
) (
   input  wire logic ref_clk,
   input  wire logic rstn,
   mtp_dt_if.dt      dtp
);
   logic [NP-1:0]        raw_ff;
   logic [NP-1:0]        nxt_raw;
   logic [NP-1:0][15:0]  cnt_ff;
   logic [NP-1:0][15:0]  nxt_cnt;
   logic [NP-1:0]        top_ff;
   logic [NP-1:0]        nxt_top;
   logic [NP-1:0]        bot_ff;
   logic [NP-1:0]        nxt_bot;

   // restart the settle count on every edge, release edge once it expires
   always_comb begin
      nxt_raw = dtp.raw;
      for (int j = 0; j < NP; j++) begin
         if (dtp.raw[j] != raw_ff[j]) begin
            nxt_cnt[j] = 16'h0000;
         end else if (cnt_ff[j] != 16'hffff) begin
            nxt_cnt[j] = cnt_ff[j] + 16'h0001;
         end else begin
            nxt_cnt[j] = cnt_ff[j];
         end
         // rising edges wait, falling edges are immediate
         nxt_top[j] = raw_ff[j] && (cnt_ff[j] >= dtp.dead);
         nxt_bot[j] = !raw_ff[j] && (cnt_ff[j] >= dtp.dead);
      end
   end

   // dead-time state
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         raw_ff <= '0;
         cnt_ff <= '0;
         top_ff <= '0;
         bot_ff <= '0;
      end else begin
         raw_ff <= nxt_raw;
         cnt_ff <= nxt_cnt;
         top_ff <= nxt_top;
         bot_ff <= nxt_bot;
      end
   end

   assign dtp.top = top_ff;
   assign dtp.bot = bot_ff;

   default clocking dt_cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   no_overlap_a: assert property (!(|(top_ff & bot_ff)))
      else $error("both outputs of a pair active");
   top_delay_a: assert property ($rose(top_ff[0]) |-> $past(raw_ff[0], 1) && $past(raw_ff[0], 2)
      || $past(dtp.dead) == 16'h0000)
      else $error("top output rose without settle time");
endmodule

// ==== verilog/mtp_pwm_timer.sv ====
// six-output center-aligned motor pwm timer with dead time and init trigger
`timescale 1ns/100ps
module mtp_pwm_timer #(
   parameter logic [15:0] MOD_DEF = mtp_pkg::MOD_RST,
   parameter logic [7:0]  POL_DEF = mtp_pkg::POL_RST
) (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        clk_gate_en,
   input  wire logic        write_protect_disable,
   input  wire logic        dbg_attached,
   input  wire logic        acc_valid,
   input  wire logic        acc_write,
   input  wire logic [3:0]  acc_addr,
   input  wire logic [15:0] acc_wdata,
   output logic             acc_ack_ff,
   output logic             acc_fault_ff,
   output logic [15:0]      acc_rdata_ff,
   output logic [7:0]       pwm_out_ff,
   output logic             init_trig_ff
);
   // signed or unsigned compare helpers
   function automatic logic cmp_lt(input logic [15:0] a, input logic [15:0] b,
                                   input logic sgn);
      cmp_lt = sgn ? ($signed(a) < $signed(b)) : (a < b);
   endfunction
   function automatic logic cmp_le(input logic [15:0] a, input logic [15:0] b,
                                   input logic sgn);
      cmp_le = sgn ? ($signed(a) <= $signed(b)) : (a <= b);
   endfunction

   logic [15:0]             cnt_ff;
   logic [15:0]             nxt_cnt;
   mtp_pkg::mtp_dir_t       dir_ff;
   mtp_pkg::mtp_dir_t       nxt_dir;
   logic [15:0]             init_ff;
   logic [15:0]             nxt_init;
   logic [15:0]             mod_ff;
   logic [15:0]             nxt_mod;
   logic [15:0]             dead_ff;
   logic [15:0]             nxt_dead;
   logic [7:0]              pol_ff;
   logic [7:0]              nxt_pol;
   logic                    sgn_ff;
   logic                    nxt_sgn;
   logic [1:0]              dbg_sel_ff;
   logic [1:0]              nxt_dbg_sel;
   logic                    trig_en_ff;
   logic                    nxt_trig_en;
   logic [7:0][15:0]        buf_ff;
   logic [7:0][15:0]        nxt_buf;
   logic [7:0][15:0]        act_ff;
   logic [7:0][15:0]        nxt_act;
   logic                    load_pend_ff;
   logic                    nxt_load_pend;
   logic                    nxt_ack;
   logic                    nxt_fault;
   logic [15:0]             nxt_rdata;
   logic                    nxt_trig;
   logic [7:0]              nxt_pwm;
   logic [7:0]              drive;
   logic [7:0]              raw;
   logic                    run;
   logic                    at_bot;
   logic                    wr_ok;
   logic                    load_req;

   mtp_dt_if #(.NP(mtp_pkg::NUM_PAIRS)) dtp ();

   // counter halts only in debug mode without the run selection
   assign run    = !(dbg_attached && (dbg_sel_ff != mtp_pkg::DBG_RUN));
   assign at_bot = (dir_ff == mtp_pkg::DIR_DOWN) && cmp_le(cnt_ff, init_ff, sgn_ff);
   assign wr_ok  = acc_valid && acc_write && clk_gate_en;
   assign load_req = wr_ok && (acc_addr == mtp_pkg::A_LOAD) && acc_wdata[mtp_pkg::B_LOAD];

   // up-down sweep between initial and modulo values
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_dir = dir_ff;
      if (run) begin
         unique case (dir_ff)
            mtp_pkg::DIR_UP: begin
               if (cmp_le(mod_ff, cnt_ff, sgn_ff)) begin
                  nxt_dir = mtp_pkg::DIR_DOWN;
                  nxt_cnt = cnt_ff - 16'h0001;
               end else begin
                  nxt_cnt = cnt_ff + 16'h0001;
               end
            end
            mtp_pkg::DIR_DOWN: begin
               if (at_bot) begin
                  nxt_dir = mtp_pkg::DIR_UP;
                  nxt_cnt = init_ff + 16'h0001;
               end else begin
                  nxt_cnt = cnt_ff - 16'h0001;
               end
            end
         endcase
      end
   end

   // counter registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cnt_ff <= mtp_pkg::INIT_RST;
         dir_ff <= mtp_pkg::DIR_UP;
      end else begin
         cnt_ff <= nxt_cnt;
         dir_ff <= nxt_dir;
      end
   end

   // register access, config writes, buffered values and commit
   always_comb begin
      nxt_init      = init_ff;
      nxt_mod       = mod_ff;
      nxt_dead      = dead_ff;
      nxt_pol       = pol_ff;
      nxt_sgn       = sgn_ff;
      nxt_dbg_sel   = dbg_sel_ff;
      nxt_trig_en   = trig_en_ff;
      nxt_buf       = buf_ff;
      nxt_act       = act_ff;
      nxt_load_pend = load_pend_ff;
      nxt_ack       = 1'b0;
      nxt_fault     = 1'b0;
      nxt_rdata     = 16'h0000;
      nxt_trig      = 1'b0;
      // commit all buffered values at the reload point
      if (run && at_bot) begin
         nxt_trig = trig_en_ff;
         if (load_pend_ff) begin
            nxt_act       = buf_ff;
            nxt_load_pend = 1'b0;
         end
      end
      if (acc_valid && !clk_gate_en) begin
         nxt_fault = 1'b1;
      end else if (acc_valid) begin
         nxt_ack = 1'b1;
         if (acc_write) begin
            if (!acc_addr[3]) begin
               nxt_buf[acc_addr[2:0]] = acc_wdata;
            end else if (write_protect_disable) begin
               unique case (acc_addr)
                  mtp_pkg::A_INIT: nxt_init = acc_wdata;
                  mtp_pkg::A_MOD:  nxt_mod  = acc_wdata;
                  mtp_pkg::A_DEAD: nxt_dead = acc_wdata;
                  mtp_pkg::A_POL:  nxt_pol  = acc_wdata[7:0];
                  mtp_pkg::A_CONF: begin
                     nxt_sgn     = acc_wdata[mtp_pkg::B_SIGNED];
                     nxt_dbg_sel = acc_wdata[mtp_pkg::B_DBG_LO +: 2];
                     nxt_trig_en = acc_wdata[mtp_pkg::B_TRIG_EN];
                  end
                  default: ;
               endcase
            end
         end else begin
            unique case (acc_addr)
               mtp_pkg::A_INIT: nxt_rdata = init_ff;
               mtp_pkg::A_MOD:  nxt_rdata = mod_ff;
               mtp_pkg::A_DEAD: nxt_rdata = dead_ff;
               mtp_pkg::A_POL:  nxt_rdata = {8'h00, pol_ff};
               mtp_pkg::A_CONF: nxt_rdata = {12'h000, trig_en_ff, dbg_sel_ff, sgn_ff};
               mtp_pkg::A_LOAD: nxt_rdata = {15'h0000, load_pend_ff};
               mtp_pkg::A_CNT:  nxt_rdata = cnt_ff;
               mtp_pkg::A_STAT: nxt_rdata = {14'h0000, dir_ff, !run};
               default:         nxt_rdata = buf_ff[acc_addr[2:0]];
            endcase
         end
      end
      // a new request wins over the commit clear
      if (load_req) begin
         nxt_load_pend = 1'b1;
      end
   end

   // configuration and access registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         init_ff      <= mtp_pkg::INIT_RST;
         mod_ff       <= MOD_DEF;
         dead_ff      <= mtp_pkg::DEAD_RST;
         pol_ff       <= POL_DEF;
         sgn_ff       <= 1'b0;
         dbg_sel_ff   <= mtp_pkg::DBG_RST;
         trig_en_ff   <= 1'b0;
         buf_ff       <= '0;
         act_ff       <= '0;
         load_pend_ff <= 1'b0;
         acc_ack_ff   <= 1'b0;
         acc_fault_ff <= 1'b0;
         acc_rdata_ff <= 16'h0000;
         init_trig_ff <= 1'b0;
      end else begin
         init_ff      <= nxt_init;
         mod_ff       <= nxt_mod;
         dead_ff      <= nxt_dead;
         pol_ff       <= nxt_pol;
         sgn_ff       <= nxt_sgn;
         dbg_sel_ff   <= nxt_dbg_sel;
         trig_en_ff   <= nxt_trig_en;
         buf_ff       <= nxt_buf;
         act_ff       <= nxt_act;
         load_pend_ff <= nxt_load_pend;
         acc_ack_ff   <= nxt_ack;
         acc_fault_ff <= nxt_fault;
         acc_rdata_ff <= nxt_rdata;
         init_trig_ff <= nxt_trig;
      end
   end

   // per-channel compare: active while count below the committed value
   always_comb begin
      for (int i = 0; i < mtp_pkg::NUM_CH; i++) begin
         raw[i] = cmp_lt(cnt_ff, act_ff[i], sgn_ff);
      end
   end

   // pairs 0/1, 2/3, 4/5 take their phase from the even channel
   assign dtp.raw  = {raw[4], raw[2], raw[0]};
   assign dtp.dead = dead_ff;
   assign drive = {raw[7], raw[6], dtp.bot[2], dtp.top[2], dtp.bot[1], dtp.top[1],
                   dtp.bot[0], dtp.top[0]};
   assign nxt_pwm = drive ^ pol_ff;

   mtp_dead_time #(.NP(mtp_pkg::NUM_PAIRS)) u_dead (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .dtp     (dtp.dt)
   );

   // output drive with polarity
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pwm_out_ff <= POL_DEF;
      end else begin
         pwm_out_ff <= nxt_pwm;
      end
   end

   default clocking pt_cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_load_req;
      load_req;
   endsequence
   sequence s_commit;
      run && at_bot;
   endsequence

   gate_fault_a: assert property (acc_valid && !clk_gate_en |=> acc_fault_ff && !acc_ack_ff)
      else $error("gated access did not fault");
   prot_block_a: assert property (wr_ok && (acc_addr == mtp_pkg::A_MOD) && !write_protect_disable
      |=> mod_ff == $past(mod_ff))
      else $error("protected modulo changed");
   dbg_freeze_a: assert property (!run |=> cnt_ff == $past(cnt_ff))
      else $error("counter moved while frozen");
   pol_out_a: assert property (##1 pwm_out_ff == $past(drive ^ pol_ff))
      else $error("output polarity wrong");
   hold_act_a: assert property (!load_pend_ff |=> act_ff == $past(act_ff))
      else $error("values changed without load confirm");
   commit_a: assert property (s_load_req ##1 (s_commit and !load_req) |=> act_ff == $past(buf_ff)
      && !load_pend_ff)
      else $error("buffered values not committed");
   trig_pulse_a: assert property (init_trig_ff |-> $past(at_bot && run && trig_en_ff))
      else $error("init trigger at wrong time");
   turn_top_a: assert property (run && dir_ff == mtp_pkg::DIR_UP && cmp_le(mod_ff, cnt_ff, sgn_ff)
      |=> dir_ff == mtp_pkg::DIR_DOWN)
      else $error("counter did not turn at modulo");
   step_up_a: assert property (run && dir_ff == mtp_pkg::DIR_UP && !cmp_le(mod_ff, cnt_ff, sgn_ff)
      |=> cnt_ff == $past(cnt_ff) + 16'h0001)
      else $error("counter did not step up");
endmodule

// ==== verification/mtp_gate_drv_model.sv ====
// behavioural model of the three-phase gate driver fed by the timer pins
`timescale 1ns/100ps
module mtp_gate_drv_model (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic [5:0] gate_in,
   input  wire logic       clr,
   output int              n_overlap,
   output int              min_gap
);
   logic [2:0] hi_on;
   logic [2:0] lo_on;
   logic [2:0] was_hi;
   int         gap [3];
   // pins carry channels 0..5 only, top inputs active low
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         hi_on[k] = !gate_in[2*k];
         lo_on[k] = gate_in[2*k+1];
      end
   end
   // count shoot-through cycles and the shortest both-off gap
   always @(posedge ref_clk) begin
      if (!rstn || clr) begin
         n_overlap = 0;
         min_gap = 999;
         was_hi = 3'h0;
         for (int k = 0; k < 3; k++) gap[k] = 1000;
      end else begin
         for (int k = 0; k < 3; k++) begin
            if (hi_on[k] && lo_on[k]) n_overlap++;
            if (!hi_on[k] && !lo_on[k]) gap[k]++;
            else begin
               // a gap only counts where the conducting side changes
               if (hi_on[k] != was_hi[k] && gap[k] < min_gap) min_gap = gap[k];
               was_hi[k] = hi_on[k];
               gap[k] = 0;
            end
         end
      end
   end
endmodule

// ==== verification/six_channel_motor_pwm_timer_tb_top.sv ====
// self-checking bench for the six-output motor pwm timer
`timescale 1ns/100ps
module six_channel_motor_pwm_timer_tb_top;
   localparam logic [15:0] MODV = 16'h0010;
   localparam logic [15:0] PER  = 16'(2 * MODV);
   logic        ref_clk, rstn, clk_gate_en, write_protect_disable, dbg_attached;
   logic        acc_valid, acc_write, acc_ack_ff, acc_fault_ff, init_trig_ff, clr;
   logic [3:0]  acc_addr;
   logic [15:0] acc_wdata, acc_rdata_ff, rd, r1, d;
   logic [7:0]  pwm_out_ff;
   logic [31:0] seed;
   int          n_mismatch, checks, n_overlap, min_gap, n, p, h;

   mtp_pwm_timer #(.MOD_DEF(MODV), .POL_DEF(mtp_pkg::POL_RST)) DUT (
      .ref_clk(ref_clk), .rstn(rstn), .clk_gate_en(clk_gate_en),
      .write_protect_disable(write_protect_disable), .dbg_attached(dbg_attached),
      .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_ack_ff(acc_ack_ff), .acc_fault_ff(acc_fault_ff),
      .acc_rdata_ff(acc_rdata_ff), .pwm_out_ff(pwm_out_ff), .init_trig_ff(init_trig_ff));
   mtp_gate_drv_model drv (.ref_clk(ref_clk), .rstn(rstn), .gate_in(pwm_out_ff[5:0]),
      .clr(clr), .n_overlap(n_overlap), .min_gap(min_gap));

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // xorshift step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // high cycles of a direct channel per period, initial value 0
   function automatic int hi_cycles(input logic [15:0] v, input logic sgn);
      if ((sgn && v[15]) || v == 16'h0000) return 0;
      if (v > MODV) return 2 * MODV;
      return 2 * v - 1;
   endfunction

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one access, answer checked one cycle after it is taken
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      acc_valid <= 1'b1;
      acc_write <= w;
      acc_addr <= a;
      acc_wdata <= v;
      @(posedge ref_clk);
      acc_valid <= 1'b0;
      acc_wdata <= ~v;
      #1;
      chk("answer", {14'h0, !clk_gate_en, clk_gate_en}, {14'h0, acc_fault_ff, acc_ack_ff});
      rd = acc_rdata_ff;
   endtask

   task automatic rdchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
      acc(1'b0, a, 16'h0000);
      chk(nm, exp, rd);
   endtask

   // cycles between two init trigger pulses
   task automatic trig_gap(output int q);
      n = 0;
      while (init_trig_ff !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      q = 0;
      do begin
         @(posedge ref_clk);
         #1;
         q++;
      end while (init_trig_ff !== 1'b1 && q < 400);
   endtask

   // high cycles of channel 6 over one period
   task automatic hi_count(output int q);
      q = 0;
      repeat (4) @(posedge ref_clk);
      repeat (PER) begin
         @(posedge ref_clk);
         #1;
         if (pwm_out_ff[6] === 1'b1) q++;
      end
   endtask

   task automatic final_report;
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      final_report;
   end

   // main sequence
   initial begin
      rstn = 1'b0;
      clk_gate_en = 1'b0;
      write_protect_disable = 1'b0;
      dbg_attached = 1'b0;
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_addr = 4'h0;
      acc_wdata = 16'h0000;
      clr = 1'b0;
      seed = 32'd89599;
      n_mismatch = 0;
      checks = 0;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      #1 chk("pwm reset", 16'h0015, {8'h00, pwm_out_ff});
      acc(1'b1, 4'h6, 16'h0011);
      @(posedge ref_clk) clk_gate_en <= 1'b1;
      rdchk("buffer after fault", 4'h6, 16'h0000);
      rdchk("modulo", mtp_pkg::A_MOD, MODV);
      rdchk("dead", mtp_pkg::A_DEAD, mtp_pkg::DEAD_RST);
      rdchk("polarity", mtp_pkg::A_POL, 16'h0015);
      acc(1'b1, mtp_pkg::A_MOD, 16'h0008);
      rdchk("modulo protected", mtp_pkg::A_MOD, MODV);
      @(posedge ref_clk) write_protect_disable <= 1'b1;
      acc(1'b1, mtp_pkg::A_CONF, 16'h0008);
      trig_gap(p);
      chk("period", PER, p[15:0]);
      acc(1'b1, mtp_pkg::A_INIT, 16'h0004);
      trig_gap(p);
      chk("period init 4", 16'(2 * (MODV - 4)), p[15:0]);
      acc(1'b1, mtp_pkg::A_INIT, 16'h0000);
      @(posedge ref_clk) dbg_attached <= 1'b1;
      acc(1'b0, mtp_pkg::A_STAT, 16'h0000);
      chk("frozen flag", 16'h0001, {rd[15:2], 1'b0, rd[0]});
      acc(1'b0, mtp_pkg::A_CNT, 16'h0000);
      r1 = rd;
      rdchk("frozen count", mtp_pkg::A_CNT, r1);
      acc(1'b1, mtp_pkg::A_CONF, 16'h000e);
      acc(1'b0, mtp_pkg::A_STAT, 16'h0000);
      chk("running flag", 16'h0000, {rd[15:2], 1'b0, rd[0]});
      trig_gap(p);
      chk("period debug run", PER, p[15:0]);
      // buffered values stay inactive until confirmed
      acc(1'b1, 4'h6, MODV + 16'h1);
      acc(1'b1, 4'h7, MODV + 16'h1);
      hi_count(h);
      chk("no load", 16'h0000, h[15:0]);
      acc(1'b1, mtp_pkg::A_LOAD, 16'h0001);
      n = 0;
      repeat (PER * 2) begin
         @(posedge ref_clk);
         #1;
         if (pwm_out_ff[6] !== pwm_out_ff[7]) n++;
      end
      chk("same instant", 16'h0000, n[15:0]);
      hi_count(h);
      chk("full duty", PER, h[15:0]);
      acc(1'b1, 4'h6, 16'hffff);
      acc(1'b1, mtp_pkg::A_CONF, 16'h000f);
      acc(1'b1, mtp_pkg::A_LOAD, 16'h0001);
      trig_gap(p);
      hi_count(h);
      chk("signed compare", 16'h0000, h[15:0]);
      acc(1'b1, mtp_pkg::A_CONF, 16'h000e);
      acc(1'b1, mtp_pkg::A_DEAD, 16'h0003);
      @(posedge ref_clk) clr <= 1'b1;
      @(posedge ref_clk) clr <= 1'b0;
      // random duties on all three pairs and the direct channel
      repeat (6) begin
         seed = xs(seed);
         d = 16'(seed[15:0] % (MODV + 16'h2));
         acc(1'b1, 4'h6, d);
         acc(1'b1, 4'h0, d);
         acc(1'b1, 4'h2, 16'(seed[31:16] % MODV));
         acc(1'b1, 4'h4, MODV - d);
         acc(1'b1, mtp_pkg::A_LOAD, 16'h0001);
         trig_gap(p);
         hi_count(h);
         chk("duty", 16'(hi_cycles(d, 1'b0)), h[15:0]);
      end
      chk("overlap", 16'h0000, n_overlap[15:0]);
      chk("dead gap", 16'h0001, {15'h0, min_gap >= 3 && min_gap < 999});
      final_report;
   end
endmodule
